// ### design/pwd_consts.svh
`ifndef PWD_CONSTS_SVH
`define PWD_CONSTS_SVH

// Register map
`define PWD_MODE_ADDR     16'hff48
`define PWD_KICK_ADDR     16'hff49
// Reset and fixed values
`define PWD_MODE_RST      8'h67
`define PWD_KICK_READ     8'h9a
`define PWD_KICK_KEY      8'hac
`define PWD_MODE_HI_FIXED 3'h3
// Mode fields
`define PWD_HI_MSB        7
`define PWD_HI_LSB        5
`define PWD_SEL_MSB       4
`define PWD_SEL_LSB       3
`define PWD_INT_MSB       2
`define PWD_INT_LSB       0
`define PWD_SEL_SLOW      2'h0
`define PWD_SEL_PERIPH    2'h1
// Overflow exponents for interval code 000
`define PWD_EXP_SLOW      5'h0b
`define PWD_EXP_PERIPH    5'h0d
// Reset cause bit and counter width
`define PWD_RESET_CAUSE_REGISTER_WDT_BIT  4
`define PWD_CNT_W         20

`endif

// ### design/pwd_pkg.sv
`include "pwd_consts.svh"

package pwd_pkg;

  // CPU memory access, one cycle per access
  typedef struct packed {
    logic [15:0] addr;
    logic        wr;
    logic        rd;
    logic        bitop;
    logic [7:0]  wdata;
  } pwd_bus_req_t;

  // Clock ticks and gating conditions from the clock controller
  typedef struct packed {
    logic slow_tick;
    logic periph_tick;
    logic periph_stopped;
    logic halt;
    logic stop;
    logic osc_stab;
    logic cpu_on_periph;
    logic slow_sw_stopped;
  } pwd_clk_env_t;

  typedef enum logic [1:0] {
    PWD_SRC_SLOW   = 2'b01,
    PWD_SRC_PERIPH = 2'b10
  } pwd_src_t;

  typedef struct packed {
    logic tick;
  } pwd_gate_st_t;

  typedef struct packed {
    logic [`PWD_CNT_W-1:0] count;
  } pwd_cnt_st_t;

  typedef struct packed {
    logic [7:0] mode;
    logic       written;
    logic       opt_cap;
    logic       opt;
    logic       rst_out;
    logic [7:0] cause;
    logic [7:0] rdata;
  } pwd_top_st_t;

  // Last count value before overflow for a given exponent
  function automatic logic [`PWD_CNT_W-1:0] pwd_limit(input logic [4:0] e);
    logic [`PWD_CNT_W:0] one;
    one = {{`PWD_CNT_W{1'b0}}, 1'b1};
    return `PWD_CNT_W'((one << e) - one);
  endfunction

endpackage

// ### design/pwd_clk_gate.sv
`include "pwd_consts.svh"

module pwd_clk_gate (
  // Clock and reset
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  // Selection
  input  wire logic              run_i,
  input  wire logic              unstop_i,
  input  wire pwd_pkg::pwd_src_t src_i,
  input  wire pwd_pkg::pwd_clk_env_t env_i,
  // Gated tick
  output logic                   tick_o
);

  pwd_pkg::pwd_gate_st_t st_q;
  pwd_pkg::pwd_gate_st_t st_d;
  logic                  slow_gate;
  logic                  per_gate;

  always_comb begin
    st_d      = st_q;
    // Unstoppable option keeps counting through HALT and STOP
    slow_gate = !unstop_i && (env_i.halt || env_i.stop ||
                (env_i.cpu_on_periph && env_i.slow_sw_stopped));
    per_gate  = env_i.periph_stopped || env_i.halt || env_i.stop || env_i.osc_stab;
    case (src_i)
      pwd_pkg::PWD_SRC_SLOW:   st_d.tick = run_i && env_i.slow_tick && !slow_gate;
      pwd_pkg::PWD_SRC_PERIPH: st_d.tick = run_i && env_i.periph_tick && !per_gate;
      default:                 st_d.tick = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tick_o = st_q.tick;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  property p_periph_gated;
    (src_i == pwd_pkg::PWD_SRC_PERIPH) && (env_i.halt || env_i.stop || env_i.osc_stab || env_i.periph_stopped)
      |=> !tick_o;
  endproperty
  a_periph_gated: assert property (p_periph_gated) else $error("Peripheral tick passed while gated");

  property p_slow_gated;
    (src_i == pwd_pkg::PWD_SRC_SLOW) && !unstop_i && (env_i.halt || env_i.stop) |=> !tick_o;
  endproperty
  a_slow_gated: assert property (p_slow_gated) else $error("Slow tick passed in halt or stop");

  property p_slow_sw_gated;
    (src_i == pwd_pkg::PWD_SRC_SLOW) && !unstop_i && env_i.cpu_on_periph && env_i.slow_sw_stopped |=> !tick_o;
  endproperty
  a_slow_sw_gated: assert property (p_slow_sw_gated) else $error("Slow tick passed while oscillator off");

  property p_unstop_runs;
    unstop_i && run_i && (src_i == pwd_pkg::PWD_SRC_SLOW) && env_i.slow_tick |=> tick_o;
  endproperty
  a_unstop_runs: assert property (p_unstop_runs) else $error("Fixed slow clock was gated");

endmodule

// ### design/pwd_counter.sv
`include "pwd_consts.svh"

module pwd_counter (
  // Clock and reset
  input  wire logic                  mclk_i,
  input  wire logic                  rst_i,
  // Control
  input  wire logic                  clr_i,
  input  wire logic                  tick_i,
  input  wire logic [4:0]            exp_i,
  // Status
  output logic [`PWD_CNT_W-1:0]      count_o,
  output logic                       ovf_o
);

  pwd_pkg::pwd_cnt_st_t st_q;
  pwd_pkg::pwd_cnt_st_t st_d;

  always_comb begin
    st_d = st_q;
    // Gated periods simply hold the count
    if (clr_i) begin
      st_d.count = '0;
    end else if (tick_i) begin
      st_d.count = st_q.count + `PWD_CNT_W'(1);
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign count_o = st_q.count;
  assign ovf_o   = tick_i && (st_q.count == pwd_pkg::pwd_limit(exp_i));

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  property p_hold;
    !clr_i && !tick_i |=> $stable(count_o);
  endproperty
  a_hold: assert property (p_hold) else $error("Count moved without a tick");

endmodule

// ### design/pwd_top.sv
`include "pwd_consts.svh"

module pwd_top (
  // Clock and reset
  input  wire logic                  mclk_i,
  input  wire logic                  rst_i,
  // CPU access
  input  wire pwd_pkg::pwd_bus_req_t bus_i,
  output logic [7:0]                 rdata_o,
  // Clock environment and option
  input  wire pwd_pkg::pwd_clk_env_t env_i,
  input  wire logic                  unstoppable_opt_i,
  // Reset request
  output logic                       wdt_reset_o,
  output logic [7:0]                 reset_cause_set_o
);

  pwd_pkg::pwd_top_st_t  st_q;
  pwd_pkg::pwd_top_st_t  st_d;
  pwd_pkg::pwd_src_t     src;
  logic                  unstop;
  logic                  stopped;
  logic                  mode_wr;
  logic                  kick_wr;
  logic                  kick_ok;
  logic                  misuse;
  logic                  fire;
  logic                  clr_cnt;
  logic [1:0]            sel;
  logic [4:0]            exp_sel;
  logic                  tick;
  logic                  ovf;
  logic [`PWD_CNT_W-1:0] count;

  // One address compare shared by write and read decode
  function automatic logic reg_hit(input logic [15:0] addr, input logic [15:0] target);
    return addr == target;
  endfunction

  // Option is a strap: caught on the first clock after release
  assign unstop  = st_q.opt_cap ? st_q.opt : unstoppable_opt_i;
  assign sel     = st_q.mode[`PWD_SEL_MSB:`PWD_SEL_LSB];
  assign stopped = !unstop && sel[1];
  assign src     = (sel == `PWD_SEL_PERIPH) ? pwd_pkg::PWD_SRC_PERIPH : pwd_pkg::PWD_SRC_SLOW;
  assign exp_sel = ((src == pwd_pkg::PWD_SRC_PERIPH) ? `PWD_EXP_PERIPH : `PWD_EXP_SLOW)
                   + {2'h0, st_q.mode[`PWD_INT_MSB:`PWD_INT_LSB]};
  assign mode_wr = bus_i.wr && reg_hit(bus_i.addr, `PWD_MODE_ADDR);
  assign kick_wr = bus_i.wr && reg_hit(bus_i.addr, `PWD_KICK_ADDR);
  assign kick_ok = kick_wr && !bus_i.bitop && (bus_i.wdata == `PWD_KICK_KEY);
  // Misuse is harmless once stopped
  assign misuse  = !stopped && ((mode_wr && st_q.written) || (kick_wr && !kick_ok));
  assign fire    = misuse || (ovf && !stopped);
  // Clearing on fire avoids a double request before rst_i arrives
  assign clr_cnt = mode_wr || kick_ok || fire;

  always_comb begin
    st_d         = st_q;
    st_d.opt_cap = 1'b1;
    if (!st_q.opt_cap) begin
      st_d.opt = unstoppable_opt_i;
    end
    if (mode_wr && !st_q.written) begin
      st_d.written = 1'b1;
      if (unstop) begin
        // Only the interval is taken; clock select and top bits fixed
        st_d.mode = {`PWD_MODE_HI_FIXED, `PWD_SEL_SLOW, bus_i.wdata[`PWD_INT_MSB:`PWD_INT_LSB]};
      end else begin
        st_d.mode = bus_i.wdata;
      end
    end
    st_d.rst_out = fire;
    st_d.cause   = 8'h00;
    if (fire) begin
      st_d.cause[`PWD_RESET_CAUSE_REGISTER_WDT_BIT] = 1'b1;
    end
    st_d.rdata = 8'h00;
    if (bus_i.rd && reg_hit(bus_i.addr, `PWD_MODE_ADDR)) begin
      st_d.rdata = st_q.mode;
    end else if (bus_i.rd && reg_hit(bus_i.addr, `PWD_KICK_ADDR)) begin
      st_d.rdata = `PWD_KICK_READ;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q      <= '0;
      st_q.mode <= `PWD_MODE_RST;
    end else begin
      st_q <= st_d;
    end
  end

  pwd_clk_gate u_gate (
    .mclk_i   (mclk_i),
    .rst_i    (rst_i),
    .run_i    (!stopped),
    .unstop_i (unstop),
    .src_i    (src),
    .env_i    (env_i),
    .tick_o   (tick)
  );

  pwd_counter u_cnt (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .clr_i   (clr_cnt),
    .tick_i  (tick),
    .exp_i   (exp_sel),
    .count_o (count),
    .ovf_o   (ovf)
  );

  assign rdata_o           = st_q.rdata;
  assign wdt_reset_o       = st_q.rst_out;
  assign reset_cause_set_o = st_q.cause;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  property p_overflow;
    tick && !stopped && (count == pwd_pkg::pwd_limit(exp_sel)) |=> wdt_reset_o;
  endproperty
  a_overflow: assert property (p_overflow) else $error("Overflow without reset");

  property p_cause;
    wdt_reset_o |-> reset_cause_set_o[`PWD_RESET_CAUSE_REGISTER_WDT_BIT];
  endproperty
  a_cause: assert property (p_cause) else $error("Reset without cause bit");

  property p_slow_exp;
    !stopped && (src == pwd_pkg::PWD_SRC_SLOW) && (st_q.mode[2:0] == 3'h7) |-> exp_sel == 5'h12;
  endproperty
  a_slow_exp: assert property (p_slow_exp) else $error("Slow exponent wrong");

  property p_per_exp;
    (src == pwd_pkg::PWD_SRC_PERIPH) && (st_q.mode[2:0] == 3'h0) |-> exp_sel == 5'h0d;
  endproperty
  a_per_exp: assert property (p_per_exp) else $error("Peripheral exponent wrong");

  property p_unstop_sel;
    unstop |-> (sel == `PWD_SEL_SLOW) && !stopped;
  endproperty
  a_unstop_sel: assert property (p_unstop_sel) else $error("Select changed under unstoppable option");

  property p_second_write;
    mode_wr && st_q.written && !stopped |=> wdt_reset_o;
  endproperty
  a_second_write: assert property (p_second_write) else $error("Second mode write not reset");

  property p_kick_clear;
    kick_ok |=> count == '0;
  endproperty
  a_kick_clear: assert property (p_kick_clear) else $error("Kick did not clear counter");

  property p_bad_kick;
    kick_wr && !stopped && (bus_i.bitop || (bus_i.wdata != `PWD_KICK_KEY)) |=> wdt_reset_o;
  endproperty
  a_bad_kick: assert property (p_bad_kick) else $error("Bad kick not reset");

  property p_kick_read;
    bus_i.rd && (bus_i.addr == `PWD_KICK_ADDR) |=> rdata_o == `PWD_KICK_READ;
  endproperty
  a_kick_read: assert property (p_kick_read) else $error("Kick read value wrong");

  property p_mode_clear;
    mode_wr |=> count == '0;
  endproperty
  a_mode_clear: assert property (p_mode_clear) else $error("Mode write did not clear counter");

  property p_stopped_quiet;
    stopped && (mode_wr || kick_wr) |=> !wdt_reset_o;
  endproperty
  a_stopped_quiet: assert property (p_stopped_quiet) else $error("Stopped watchdog reset");

  property p_reset_mode;
    !st_q.written |-> st_q.mode == `PWD_MODE_RST;
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("Mode left reset value before a write");

  property p_reset_src;
    !st_q.written |-> (src == pwd_pkg::PWD_SRC_SLOW) && !stopped;
  endproperty
  a_reset_src: assert property (p_reset_src) else $error("Not counting slow clock after reset");

  property p_mode_frozen;
    st_q.written |=> $stable(st_q.mode);
  endproperty
  a_mode_frozen: assert property (p_mode_frozen) else $error("Mode changed after its one write");

  property p_first_write;
    mode_wr && !st_q.written && !unstop |=> st_q.mode == $past(bus_i.wdata);
  endproperty
  a_first_write: assert property (p_first_write) else $error("First mode write not taken");

  property p_unstop_write;
    mode_wr && !st_q.written && unstop
      |=> st_q.mode[`PWD_INT_MSB:`PWD_INT_LSB] == $past(bus_i.wdata[`PWD_INT_MSB:`PWD_INT_LSB]);
  endproperty
  a_unstop_write: assert property (p_unstop_write) else $error("Interval not taken under fixed clock");

  property p_unstop_hi;
    unstop |-> st_q.mode[`PWD_HI_MSB:`PWD_HI_LSB] == `PWD_MODE_HI_FIXED;
  endproperty
  a_unstop_hi: assert property (p_unstop_hi) else $error("Top mode bits not fixed");

  property p_bitop_kick;
    kick_wr && bus_i.bitop && !stopped |=> wdt_reset_o;
  endproperty
  a_bitop_kick: assert property (p_bitop_kick) else $error("Bit operation on kick not reset");

  property p_good_kick_quiet;
    kick_ok && !ovf |=> !wdt_reset_o;
  endproperty
  a_good_kick_quiet: assert property (p_good_kick_quiet) else $error("Correct key caused a reset");

  property p_first_mode_quiet;
    mode_wr && !st_q.written && !ovf |=> !wdt_reset_o;
  endproperty
  a_first_mode_quiet: assert property (p_first_mode_quiet) else $error("First mode write caused a reset");

  property p_stopped_idle;
    stopped && $past(stopped) |-> !tick;
  endproperty
  a_stopped_idle: assert property (p_stopped_idle) else $error("Tick seen while stopped");

  property p_sel_periph;
    !unstop && (sel == `PWD_SEL_PERIPH) |-> src == pwd_pkg::PWD_SRC_PERIPH;
  endproperty
  a_sel_periph: assert property (p_sel_periph) else $error("Peripheral select not honoured");

  property p_sel_slow;
    (sel == `PWD_SEL_SLOW) |-> src == pwd_pkg::PWD_SRC_SLOW;
  endproperty
  a_sel_slow: assert property (p_sel_slow) else $error("Slow select not honoured");

  property p_tick_count;
    tick && !clr_cnt |=> count == $past(count) + `PWD_CNT_W'(1);
  endproperty
  a_tick_count: assert property (p_tick_count) else $error("Tick did not advance the count");

  property p_cause_clean;
    (reset_cause_set_o & ~(8'h01 << `PWD_RESET_CAUSE_REGISTER_WDT_BIT)) == 8'h00;
  endproperty
  a_cause_clean: assert property (p_cause_clean) else $error("Foreign cause bit set");

  property p_cause_only;
    reset_cause_set_o[`PWD_RESET_CAUSE_REGISTER_WDT_BIT] |-> wdt_reset_o;
  endproperty
  a_cause_only: assert property (p_cause_only) else $error("Cause bit without reset");

  property p_mode_read;
    bus_i.rd && reg_hit(bus_i.addr, `PWD_MODE_ADDR) |=> rdata_o == $past(st_q.mode);
  endproperty
  a_mode_read: assert property (p_mode_read) else $error("Mode read value wrong");

  property p_slow_range;
    !stopped && (src == pwd_pkg::PWD_SRC_SLOW) |-> (exp_sel >= 5'h0b) && (exp_sel <= 5'h12);
  endproperty
  a_slow_range: assert property (p_slow_range) else $error("Slow exponent out of range");

  property p_per_range;
    (src == pwd_pkg::PWD_SRC_PERIPH) |-> (exp_sel >= 5'h0d) && (exp_sel <= 5'h14);
  endproperty
  a_per_range: assert property (p_per_range) else $error("Peripheral exponent out of range");

  property p_per_max;
    (src == pwd_pkg::PWD_SRC_PERIPH) && (st_q.mode[2:0] == 3'h7) |-> exp_sel == 5'h14;
  endproperty
  a_per_max: assert property (p_per_max) else $error("Peripheral longest exponent wrong");

  property p_slow_min;
    (src == pwd_pkg::PWD_SRC_SLOW) && (st_q.mode[2:0] == 3'h0) |-> exp_sel == 5'h0b;
  endproperty
  a_slow_min: assert property (p_slow_min) else $error("Slow shortest exponent wrong");

  // A pending request must not leave a stale count behind
  property p_fire_clear;
    wdt_reset_o |-> count == '0;
  endproperty
  a_fire_clear: assert property (p_fire_clear) else $error("Count not cleared with reset request");

  c_fire:    cover property (wdt_reset_o);
  c_kick:    cover property (kick_ok);
  c_stopped: cover property (mode_wr && !st_q.written && bus_i.wdata[`PWD_SEL_MSB]);
  c_periph:  cover property (src == pwd_pkg::PWD_SRC_PERIPH && tick);
  c_unstop:  cover property (unstop && mode_wr);

endmodule

// ### dv/pwd_cpu_model.sv
module pwd_cpu_model (
  // Clock
  input  wire logic             mclk_i,
  // Bus
  input  wire logic [7:0]       rdata_i,
  output pwd_pkg::pwd_bus_req_t bus_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial bus_o = '0;

  // Byte store; bitop only where a test asks for misuse
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic b);
    @(posedge mclk_i);
    bus_o <= '{addr: a, wr: 1'b1, rd: 1'b0, bitop: b, wdata: d};
    @(posedge mclk_i);
    bus_o <= '0;
  endtask

  // Data taken once the registered answer has landed
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    bus_o <= '{addr: a, wr: 1'b0, rd: 1'b1, bitop: 1'b0, wdata: 8'h00};
    @(posedge mclk_i);
    bus_o <= '0;
    #1 d = rdata_i;
  endtask
endmodule

// ### dv/test_pwd_top.sv
`include "pwd_consts.svh"

module test_pwd_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] SLOW = 8'h80;
  localparam logic [7:0] PER  = 8'h40;
  logic                  mclk_i      = 1'b0;
  logic                  rst_i       = 1'b1;
  logic                  opt         = 1'b0;
  pwd_pkg::pwd_clk_env_t env         = '0;
  pwd_pkg::pwd_bus_req_t bus;
  logic [7:0]            rdata;
  logic [7:0]            cause;
  logic                  fire;
  int                    miscompares = 0;
  int                    n_checks    = 0;
  int                    fires       = 0;

  always #10 mclk_i = ~mclk_i;

  pwd_top u_dut (
    .mclk_i            (mclk_i),
    .rst_i             (rst_i),
    .bus_i             (bus),
    .rdata_o           (rdata),
    .env_i             (env),
    .unstoppable_opt_i (opt),
    .wdt_reset_o       (fire),
    .reset_cause_set_o (cause)
  );

  pwd_cpu_model u_cpu (
    .mclk_i  (mclk_i),
    .rdata_i (rdata),
    .bus_o   (bus)
  );

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %0h seen %0h", s, e, g);
    end
  endtask

  // Every reset pulse must carry the cause bit; mid-cycle, clear of the launching edge
  always @(negedge mclk_i) begin
    if (fire === 1'b1) begin
      fires++;
      chk("cause", 32'h10, {24'h0, cause});
    end
  end

  task automatic test_done();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic reset_dut(input logic o);
    @(posedge mclk_i);
    rst_i <= 1'b1;
    opt <= o;
    env <= '0;
    repeat (8) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
  endtask

  // Write, then count reset pulses it caused
  task automatic misuse(input logic [15:0] a, input logic [7:0] d, input logic b, input int n);
    int f0;
    f0 = fires;
    u_cpu.wr(a, d, b);
    repeat (3) @(posedge mclk_i);
    #1 chk("reset pulses", n, fires - f0);
  endtask

  // Ticks every cycle with mask m held; stops early on a reset pulse
  task automatic run(input logic [7:0] m, input int lim, output int k);
    @(posedge mclk_i) env <= pwd_pkg::pwd_clk_env_t'(env | m);
    k = 0;
    while (k < lim && fire !== 1'b1) begin
      @(negedge mclk_i) k++;
    end
    @(posedge mclk_i) env <= pwd_pkg::pwd_clk_env_t'(env & ~m);
  endtask

  task automatic quiet(input logic [7:0] m, input int lim);
    int k;
    run(m, lim, k);
    chk("ticks without reset", lim, k);
  endtask

  // Slack covers pipeline and gate edges, far below a factor of two
  task automatic expect_fire(input logic [7:0] m, input int e);
    int k;
    run(m, e + 16, k);
    n_checks++;
    if (k < e - 8 || k > e + 8) begin
      miscompares++;
      $display("MISMATCH overflow ticks expected %0d seen %0d", e, k);
    end
  endtask

  task automatic t_regs();
    logic [7:0] d;
    reset_dut(1'b0);
    u_cpu.rd(`PWD_MODE_ADDR, d);
    chk("mode reset", `PWD_MODE_RST, d);
    u_cpu.rd(`PWD_KICK_ADDR, d);
    chk("kick reset", `PWD_KICK_READ, d);
    misuse(`PWD_KICK_ADDR, `PWD_KICK_KEY, 1'b0, 0);
    u_cpu.rd(`PWD_KICK_ADDR, d);
    chk("kick read", `PWD_KICK_READ, d);
    u_cpu.rd(16'hff4a, d);
    chk("unmapped read", 8'h00, d);
  endtask

  task automatic t_misuse();
    logic [7:0] d;
    reset_dut(1'b0);
    misuse(`PWD_KICK_ADDR, 8'h12, 1'b0, 1);
    reset_dut(1'b0);
    misuse(`PWD_KICK_ADDR, `PWD_KICK_KEY, 1'b1, 1);
    reset_dut(1'b0);
    misuse(`PWD_MODE_ADDR, 8'h67, 1'b0, 0);
    misuse(`PWD_MODE_ADDR, 8'h60, 1'b0, 1);
    u_cpu.rd(`PWD_MODE_ADDR, d);
    chk("mode kept", 8'h67, d);
  endtask

  task automatic t_slow();
    reset_dut(1'b0);
    quiet(SLOW, 1000);
    misuse(`PWD_MODE_ADDR, 8'h60, 1'b0, 0);
    quiet(SLOW, 1500);
    misuse(`PWD_KICK_ADDR, `PWD_KICK_KEY, 1'b0, 0);
    quiet(SLOW, 1500);
    expect_fire(SLOW, 548);
  endtask

  task automatic t_periph();
    reset_dut(1'b0);
    misuse(`PWD_MODE_ADDR, 8'h68, 1'b0, 0);
    quiet(SLOW, 3000);
    quiet(PER, 4000);
    for (int i = 2; i < 6; i++) quiet(PER | (8'h01 << i), 1000);
    expect_fire(PER, 4192);
  endtask

  task automatic t_slow_gate();
    reset_dut(1'b0);
    misuse(`PWD_MODE_ADDR, 8'h60, 1'b0, 0);
    quiet(SLOW, 1000);
    quiet(SLOW | 8'h10, 1000);
    quiet(SLOW | 8'h08, 1000);
    quiet(SLOW | 8'h03, 1000);
    quiet(SLOW | 8'h02, 500);
    expect_fire(SLOW, 548);
  endtask

  task automatic t_unstop();
    logic [7:0] d;
    reset_dut(1'b1);
    misuse(`PWD_MODE_ADDR, 8'hf9, 1'b0, 0);
    u_cpu.rd(`PWD_MODE_ADDR, d);
    chk("forced mode", 8'h61, d);
    expect_fire(SLOW | 8'h1b, 4096);
  endtask

  task automatic t_stopped();
    reset_dut(1'b0);
    misuse(`PWD_MODE_ADDR, 8'h70, 1'b0, 0);
    quiet(SLOW | PER, 5000);
    misuse(`PWD_MODE_ADDR, 8'h60, 1'b0, 0);
    misuse(`PWD_KICK_ADDR, 8'h12, 1'b0, 0);
    misuse(`PWD_KICK_ADDR, `PWD_KICK_KEY, 1'b1, 0);
  endtask

  // About 34k cycles expected; this cuts a hang at 80k
  initial begin
    #1600000;
    miscompares++;
    $display("MISMATCH run time expected done seen timeout");
    test_done();
  end

  initial begin
    t_regs();
    t_misuse();
    t_slow();
    t_periph();
    t_slow_gate();
    t_unstop();
    t_stopped();
    test_done();
  end
endmodule
